// ==== design/dffs_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Left full flag releases on next left edge if first skew met, else one later.
// - Right full flag releases on next right edge if first skew met, else one later.
// - Right almost-empty goes high next right edge if second skew met, else later.
// - Left almost-empty goes high next left edge if second skew met, else later.
// - Left almost-full goes high next left edge if second skew met, else later.
// - Right almost-full goes high next right edge if second skew met, else later.
// - Narrow right port: full flag asserts only on the last piece written.
// - Narrow right port: almost-empty asserts on first piece read of a word.
// - Narrow right port: almost-full asserts on the last piece written.
// - Narrow right port: left full skew counts from the first piece read.
// - Narrow right port: left almost-empty skew counts from last piece written.
// - Narrow right port: left almost-full skew counts from the first piece read.
// - Forward write is left select, write, no mailbox; read likewise on right.
// - Reverse write is right select, write, no mailbox; read likewise on left.
// - Narrow right port: empty flag asserts on the last piece read out.
module dffs_top
  import dffs_pkg::*;
#(
  parameter int WIDTH = DFFS_WORD_W,
  parameter int DEPTH = DFFS_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic left_port_clock_in,
  input wire logic left_chip_select_n_in,
  input wire logic left_write_not_read_in,
  input wire logic left_mailbox_select_in,
  input wire logic left_transfer_enable_in,
  input wire logic [DFFS_WORD_W-1:0] left_data_in,
  output logic [DFFS_WORD_W-1:0] left_data_out,
  output logic left_full_n_out,
  output logic left_almost_full_n_out,
  output logic left_empty_n_out,
  output logic left_almost_empty_n_out,
  input wire logic right_port_clock_in,
  input wire logic right_chip_select_n_in,
  input wire logic right_write_not_read_in,
  input wire logic right_mailbox_select_in,
  input wire logic right_transfer_enable_in,
  input wire logic right_size_sel_lo_in,
  input wire logic right_size_sel_hi_in,
  input wire logic [DFFS_WORD_W-1:0] right_data_in,
  output logic [DFFS_WORD_W-1:0] right_data_out,
  output logic right_full_n_out,
  output logic right_almost_full_n_out,
  output logic right_empty_n_out,
  output logic right_almost_empty_n_out
);

  localparam int LPW = DFFS_WORD_W + 5;
  localparam int RPW = DFFS_WORD_W + 7;
  localparam int LW = DFFS_LEVEL_W;

  function automatic logic [2:0] piece_count(input logic [1:0] size);
    unique case (size)
      DFFS_SIZE_WORD: return DFFS_HALF_PIECES;
      DFFS_SIZE_BYTE: return DFFS_BYTE_PIECES;
      default: return DFFS_LONG_PIECES;
    endcase
  endfunction

  function automatic logic [5:0] piece_width(input logic [1:0] size);
    unique case (size)
      DFFS_SIZE_WORD: return DFFS_HALF_W;
      DFFS_SIZE_BYTE: return DFFS_BYTE_W;
      default: return DFFS_LONG_W;
    endcase
  endfunction

  function automatic logic [DFFS_WORD_W-1:0] piece_mask(input logic [1:0] size);
    return ~({DFFS_WORD_W{1'b1}} << piece_width(size));
  endfunction

  // Pins are asynchronous to sys_clk_in; all go through the same two stages so
  // control and data stay aligned with the port clock's sampled edge.
  logic [LPW-1:0] left_meta_q;
  logic [LPW-1:0] left_sync_q;
  logic left_clk_prev_q;
  logic [RPW-1:0] right_meta_q;
  logic [RPW-1:0] right_sync_q;
  logic right_clk_prev_q;

  wire [LPW-1:0] left_pins = {left_port_clock_in, left_chip_select_n_in,
    left_write_not_read_in, left_mailbox_select_in, left_transfer_enable_in, left_data_in};
  wire [RPW-1:0] right_pins = {right_port_clock_in, right_chip_select_n_in,
    right_write_not_read_in, right_mailbox_select_in, right_transfer_enable_in,
    right_size_sel_hi_in, right_size_sel_lo_in, right_data_in};

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      left_meta_q <= '0;
      left_sync_q <= '0;
      left_clk_prev_q <= 1'h0;
      right_meta_q <= '0;
      right_sync_q <= '0;
      right_clk_prev_q <= 1'h0;
    end else begin
      left_meta_q <= left_pins;
      left_sync_q <= left_meta_q;
      left_clk_prev_q <= left_sync_q[LPW-1];
      right_meta_q <= right_pins;
      right_sync_q <= right_meta_q;
      right_clk_prev_q <= right_sync_q[RPW-1];
    end
  end

  // Left port decode
  wire left_edge = left_sync_q[LPW-1] && !left_clk_prev_q;
  wire left_cs_n = left_sync_q[LPW-2];
  wire left_wnr = left_sync_q[LPW-3];
  wire left_mb = left_sync_q[LPW-4];
  wire left_en = left_sync_q[LPW-5];
  wire [DFFS_WORD_W-1:0] left_din = left_sync_q[DFFS_WORD_W-1:0];
  wire left_queue_sel = left_edge && !left_cs_n && !left_mb && left_en;
  wire fwd_push_req = left_queue_sel && left_wnr;
  wire rev_pop_req = left_queue_sel && !left_wnr;

  // Right port decode
  wire right_edge = right_sync_q[RPW-1] && !right_clk_prev_q;
  wire right_cs_n = right_sync_q[RPW-2];
  wire right_wnr = right_sync_q[RPW-3];
  wire right_mb = right_sync_q[RPW-4];
  wire right_en = right_sync_q[RPW-5];
  wire [1:0] right_size = right_sync_q[RPW-6:RPW-7];
  wire [DFFS_WORD_W-1:0] right_din = right_sync_q[DFFS_WORD_W-1:0];
  // Both size selects high address the mailbox, which this block leaves alone
  wire right_queue_sel = right_edge && !right_cs_n && !right_mb && right_en
    && (right_size != DFFS_SIZE_MAIL);
  wire right_wr = right_queue_sel && right_wnr;
  wire right_rd = right_queue_sel && !right_wnr;
  wire [2:0] right_pieces = piece_count(right_size);
  wire [5:0] right_pw = piece_width(right_size);
  wire [DFFS_WORD_W-1:0] right_mask = piece_mask(right_size);

  // Queue wiring
  logic fwd_in_ready;
  logic fwd_out_valid;
  logic [DFFS_WORD_W-1:0] fwd_out_data;
  logic [LW-1:0] fwd_level_next;
  logic rev_in_ready;
  logic rev_out_valid;
  logic [DFFS_WORD_W-1:0] rev_out_data;
  logic [LW-1:0] rev_level_next;

  // Right-port write assembly into the reverse queue
  logic [1:0] wr_idx_q;
  logic [DFFS_WORD_W-1:0] wr_buf_q;
  wire [5:0] wr_shift = 6'(wr_idx_q) * right_pw;
  wire [DFFS_WORD_W-1:0] wr_buf_d = wr_buf_q | ((right_din & right_mask) << wr_shift);
  wire wr_last = (3'(wr_idx_q) + 3'h1) == right_pieces;
  // Only the piece that completes a long word touches the queue
  wire rev_push_req = right_wr && wr_last;
  // A refused last piece is kept pending so the writer may retry it
  wire wr_step = right_wr && (!wr_last || rev_in_ready);

  // Right-port read split from the forward queue
  logic [2:0] rd_left_q;
  logic [1:0] rd_idx_q;
  logic [DFFS_WORD_W-1:0] rd_word_q;
  wire rd_first = rd_left_q == 3'h0;
  // The queue entry leaves on the first piece; the rest are served from rd_word_q
  wire fwd_pop_req = right_rd && rd_first;
  wire fwd_pop = fwd_pop_req && fwd_out_valid;
  wire rd_more = right_rd && !rd_first;
  wire [5:0] rd_shift = 6'(rd_idx_q) * right_pw;
  wire [2:0] rd_left_d = fwd_pop ? (right_pieces - 3'h1) :
    (rd_more ? (rd_left_q - 3'h1) : rd_left_q);
  wire [DFFS_WORD_W-1:0] rd_piece = (rd_word_q >> rd_shift) & right_mask;

  dffs_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .LW(LW)
  ) u_forward_queue (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(fwd_push_req),
    .in_ready_out(fwd_in_ready),
    .in_data_in(left_din),
    .out_valid_out(fwd_out_valid),
    .out_ready_in(fwd_pop_req),
    .out_data_out(fwd_out_data),
    .level_out(),
    .level_next_out(fwd_level_next)
  );

  dffs_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .LW(LW)
  ) u_reverse_queue (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(rev_push_req),
    .in_ready_out(rev_in_ready),
    .in_data_in(wr_buf_d),
    .out_valid_out(rev_out_valid),
    .out_ready_in(rev_pop_req),
    .out_data_out(rev_out_data),
    .level_out(),
    .level_next_out(rev_level_next)
  );

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_idx_q <= 2'h0;
      wr_buf_q <= '0;
    end else if (wr_step) begin
      wr_idx_q <= wr_last ? 2'h0 : wr_idx_q + 2'h1;
      wr_buf_q <= wr_last ? '0 : wr_buf_d;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_left_q <= 3'h0;
      rd_idx_q <= 2'h0;
      rd_word_q <= '0;
      right_data_out <= '0;
    end else if (fwd_pop) begin
      rd_left_q <= rd_left_d;
      rd_idx_q <= 2'h1;
      rd_word_q <= fwd_out_data;
      right_data_out <= fwd_out_data & right_mask;
    end else if (rd_more) begin
      rd_left_q <= rd_left_d;
      rd_idx_q <= rd_idx_q + 2'h1;
      right_data_out <= rd_piece;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      left_data_out <= '0;
    end else if (rev_pop_req && rev_out_valid) begin
      left_data_out <= rev_out_data;
    end
  end

  // Flag conditions use the level after this cycle's own access, so a port's
  // own access moves its flag at that very edge; the far side's moves wait skew.
  wire fwd_full = fwd_level_next == DFFS_FULL_LVL;
  wire fwd_af = fwd_level_next >= DFFS_AF_LVL;
  wire fwd_empty = (fwd_level_next == DFFS_EMPTY_LVL) && (rd_left_d == 3'h0);
  // Almost-empty follows the queue level alone, so it asserts on the first piece read
  wire fwd_ae = fwd_level_next <= DFFS_AE_LVL;
  wire rev_full = rev_level_next == DFFS_FULL_LVL;
  wire rev_af = rev_level_next >= DFFS_AF_LVL;
  wire rev_empty = rev_level_next == DFFS_EMPTY_LVL;
  wire rev_ae = rev_level_next <= DFFS_AE_LVL;

  dffs_flag_sync #(.SKEW_CYC(DFFS_SKEW_FIRST_CYC), .RESET_FLAG_N(DFFS_RST_FLAG_IDLE_N))
  u_left_full (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .obs_edge_in(left_edge),
    .cond_in(fwd_full),
    .flag_n_out(left_full_n_out)
  );

  dffs_flag_sync #(.SKEW_CYC(DFFS_SKEW_SECOND_CYC), .RESET_FLAG_N(DFFS_RST_FLAG_IDLE_N))
  u_left_almost_full (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .obs_edge_in(left_edge),
    .cond_in(fwd_af),
    .flag_n_out(left_almost_full_n_out)
  );

  dffs_flag_sync #(.SKEW_CYC(DFFS_SKEW_FIRST_CYC), .RESET_FLAG_N(DFFS_RST_FLAG_ACTIVE_N))
  u_left_empty (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .obs_edge_in(left_edge),
    .cond_in(rev_empty),
    .flag_n_out(left_empty_n_out)
  );

  dffs_flag_sync #(.SKEW_CYC(DFFS_SKEW_SECOND_CYC), .RESET_FLAG_N(DFFS_RST_FLAG_ACTIVE_N))
  u_left_almost_empty (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .obs_edge_in(left_edge),
    .cond_in(rev_ae),
    .flag_n_out(left_almost_empty_n_out)
  );

  dffs_flag_sync #(.SKEW_CYC(DFFS_SKEW_FIRST_CYC), .RESET_FLAG_N(DFFS_RST_FLAG_IDLE_N))
  u_right_full (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .obs_edge_in(right_edge),
    .cond_in(rev_full),
    .flag_n_out(right_full_n_out)
  );

  dffs_flag_sync #(.SKEW_CYC(DFFS_SKEW_SECOND_CYC), .RESET_FLAG_N(DFFS_RST_FLAG_IDLE_N))
  u_right_almost_full (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .obs_edge_in(right_edge),
    .cond_in(rev_af),
    .flag_n_out(right_almost_full_n_out)
  );

  dffs_flag_sync #(.SKEW_CYC(DFFS_SKEW_FIRST_CYC), .RESET_FLAG_N(DFFS_RST_FLAG_ACTIVE_N))
  u_right_empty (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .obs_edge_in(right_edge),
    .cond_in(fwd_empty),
    .flag_n_out(right_empty_n_out)
  );

  dffs_flag_sync #(.SKEW_CYC(DFFS_SKEW_SECOND_CYC), .RESET_FLAG_N(DFFS_RST_FLAG_ACTIVE_N))
  u_right_almost_empty (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .obs_edge_in(right_edge),
    .cond_in(fwd_ae),
    .flag_n_out(right_almost_empty_n_out)
  );

endmodule // dffs_top
`default_nettype wire

// ==== design/dffs_pkg.sv ====
package dffs_pkg;

  // System clock and flag skew minimums
  localparam int DFFS_CLK_PERIOD_NS = 100;
  localparam int DFFS_SKEW_FIRST_NS = 8;
  localparam int DFFS_SKEW_SECOND_NS = 9;

  // Least times round up to whole cycles, never below one
  function automatic int dffs_min_cycles(input int ns);
    int c;
    c = (ns + DFFS_CLK_PERIOD_NS - 1) / DFFS_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int DFFS_SKEW_FIRST_CYC = dffs_min_cycles(DFFS_SKEW_FIRST_NS);
  localparam int DFFS_SKEW_SECOND_CYC = dffs_min_cycles(DFFS_SKEW_SECOND_NS);

  // Queue geometry and almost thresholds
  localparam int DFFS_WORD_W = 36;
  localparam int DFFS_DEPTH = 32;
  localparam int DFFS_LEVEL_W = $clog2(DFFS_DEPTH + 1);
  localparam logic [DFFS_LEVEL_W-1:0] DFFS_EMPTY_LVL = 6'h00;
  localparam logic [DFFS_LEVEL_W-1:0] DFFS_FULL_LVL = 6'h20;
  localparam logic [DFFS_LEVEL_W-1:0] DFFS_AE_LVL = 6'h08;
  localparam logic [DFFS_LEVEL_W-1:0] DFFS_AF_LVL = 6'h18;

  // Right-port bus sizing, code is {size_sel_hi, size_sel_lo}
  localparam logic [1:0] DFFS_SIZE_LONG = 2'h0;
  localparam logic [1:0] DFFS_SIZE_WORD = 2'h1;
  localparam logic [1:0] DFFS_SIZE_BYTE = 2'h2;
  localparam logic [1:0] DFFS_SIZE_MAIL = 2'h3;
  localparam logic [5:0] DFFS_LONG_W = 6'h24;
  localparam logic [5:0] DFFS_HALF_W = 6'h12;
  localparam logic [5:0] DFFS_BYTE_W = 6'h09;
  localparam logic [2:0] DFFS_LONG_PIECES = 3'h1;
  localparam logic [2:0] DFFS_HALF_PIECES = 3'h2;
  localparam logic [2:0] DFFS_BYTE_PIECES = 3'h4;

  // Reset values of the flag synchronisers
  localparam logic DFFS_RST_FLAG_IDLE_N = 1'h1;
  localparam logic DFFS_RST_FLAG_ACTIVE_N = 1'h0;

endpackage

// ==== design/dffs_flag_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module dffs_flag_sync
  import dffs_pkg::*;
#(
  parameter int SKEW_CYC = 1,
  parameter logic RESET_FLAG_N = 1'h1
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic obs_edge_in,
  input wire logic cond_in,
  output logic flag_n_out
);

  logic cond_q;
  logic [7:0] age_q;
  logic stage_n_q;
  logic flag_n_q;

  wire changed = cond_in != cond_q;
  // Change old enough to meet the skew minimum at this observer edge
  wire aged = !changed && (age_q >= SKEW_CYC[7:0]);
  wire [7:0] age_d = changed ? 8'h01 : ((age_q == 8'hff) ? age_q : age_q + 8'h01);

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cond_q <= ~RESET_FLAG_N;
      age_q <= 8'hff;
      stage_n_q <= RESET_FLAG_N;
      flag_n_q <= RESET_FLAG_N;
    end else begin
      cond_q <= cond_in;
      age_q <= age_d;
      if (obs_edge_in) begin
        stage_n_q <= ~cond_in;
        if (cond_in) begin
          flag_n_q <= 1'h0;
        end else if (aged) begin
          flag_n_q <= 1'h1;
        end else begin
          // Skew missed: release waits for the second stage
          flag_n_q <= stage_n_q;
        end
      end
    end
  end

  assign flag_n_out = flag_n_q;

endmodule // dffs_flag_sync
`default_nettype wire

// ==== design/dffs_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module dffs_fifo
  import dffs_pkg::*;
#(
  parameter int WIDTH = DFFS_WORD_W,
  parameter int DEPTH = DFFS_DEPTH,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [LW-1:0] level_out,
  output logic [LW-1:0] level_next_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [LW-1:0] level_q;

  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = level_q != LW'(DEPTH);
  assign out_valid_out = level_q != '0;
  assign out_data_out = mem_q[rd_ptr_q];
  assign level_out = level_q;
  assign level_next_out = level_q + LW'(push) - LW'(pop);

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
    end else begin
      level_q <= level_next_out;
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + AW'(1);
      end
    end
  end

endmodule // dffs_fifo
`default_nettype wire

// ==== sim/dffs_port_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
module dffs_port_partner #(
  parameter int HALF_NS = 400,
  parameter int PHASE_NS = 30
) (
  output var logic port_clk_out
);
  // Free-running like a real port clock; the phase keeps its edges off the system clock
  initial begin
    port_clk_out = 1'b0;
    #(PHASE_NS);
    forever #(HALF_NS) port_clk_out = ~port_clk_out;
  end
endmodule // dffs_port_partner
`default_nettype wire

// ==== sim/dffs_top_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module dffs_checker
  import dffs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic left_port_clock_in,
  input wire logic left_chip_select_n_in,
  input wire logic left_write_not_read_in,
  input wire logic left_mailbox_select_in,
  input wire logic left_transfer_enable_in,
  input wire logic [DFFS_WORD_W-1:0] left_data_out,
  input wire logic left_full_n_out,
  input wire logic left_almost_full_n_out,
  input wire logic left_empty_n_out,
  input wire logic left_almost_empty_n_out,
  input wire logic right_port_clock_in,
  input wire logic right_chip_select_n_in,
  input wire logic right_write_not_read_in,
  input wire logic right_mailbox_select_in,
  input wire logic right_transfer_enable_in,
  input wire logic right_size_sel_lo_in,
  input wire logic right_size_sel_hi_in,
  input wire logic right_full_n_out,
  input wire logic right_almost_full_n_out,
  input wire logic right_empty_n_out,
  input wire logic right_almost_empty_n_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic lp_q, rp_q;
  logic [3:0] lcnt_q, rcnt_q;
  wire logic l_sel = !left_chip_select_n_in && !left_mailbox_select_in && left_transfer_enable_in;
  wire logic l_wr = l_sel && left_write_not_read_in;
  wire logic l_rd = l_sel && !left_write_not_read_in;
  wire logic r_wr = !right_chip_select_n_in && !right_mailbox_select_in && right_transfer_enable_in
    && right_write_not_read_in && !(right_size_sel_hi_in && right_size_sel_lo_in);
  // Cycles since each port pin was first seen high, saturating
  wire logic [3:0] lcnt_d = (left_port_clock_in && !lp_q) ? 4'h0 : lcnt_q + {3'h0, lcnt_q != 4'hf};
  wire logic [3:0] rcnt_d = (right_port_clock_in && !rp_q) ? 4'h0 : rcnt_q + {3'h0, rcnt_q != 4'hf};
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {lp_q, rp_q} <= 2'h0;
      {lcnt_q, rcnt_q} <= 8'hff;
    end else begin
      {lp_q, rp_q} <= {left_port_clock_in, right_port_clock_in};
      {lcnt_q, rcnt_q} <= {lcnt_d, rcnt_d};
    end
  end
  property p_rst_vals;
    $fell(sys_rst_in) |-> {left_full_n_out, left_almost_full_n_out, left_empty_n_out,
      left_almost_empty_n_out, right_full_n_out, right_empty_n_out} == 6'h32;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("flags wrong after reset");
  property p_left_sync;
    $changed({left_full_n_out, left_almost_full_n_out, left_empty_n_out,
      left_almost_empty_n_out}) |-> lcnt_q <= 4'h6;
  endproperty
  a_left_sync: assert property (p_left_sync) else $error("left flag moved off its clock");
  property p_right_sync;
    $changed({right_full_n_out, right_almost_full_n_out, right_empty_n_out,
      right_almost_empty_n_out}) |-> rcnt_q <= 4'h6;
  endproperty
  a_right_sync: assert property (p_right_sync) else $error("right flag moved off its clock");
  property p_lfull_cause;
    $fell(left_full_n_out) |-> $past(l_wr, 2);
  endproperty
  a_lfull_cause: assert property (p_lfull_cause) else $error("left full without write");
  property p_lempty_cause;
    $fell(left_empty_n_out) |-> $past(l_rd, 2);
  endproperty
  a_lempty_cause: assert property (p_lempty_cause) else $error("left empty without read");
  property p_rfull_cause;
    $fell(right_full_n_out) |-> $past(r_wr, 2);
  endproperty
  a_rfull_cause: assert property (p_rfull_cause) else $error("right full without write");
  property p_lfull_af;
    !left_full_n_out |-> !left_almost_full_n_out;
  endproperty
  a_lfull_af: assert property (p_lfull_af) else $error("full without almost full");
  property p_rempty_ae;
    !right_empty_n_out |-> !right_almost_empty_n_out;
  endproperty
  a_rempty_ae: assert property (p_rempty_ae) else $error("empty without almost empty");
  property p_ldata;
    $changed(left_data_out) |-> $past(l_rd, 2);
  endproperty
  a_ldata: assert property (p_ldata) else $error("left data moved without read");
  c_lfull: cover property ($fell(left_full_n_out));
  c_rfull: cover property ($fell(right_full_n_out));
  c_lae: cover property ($rose(left_almost_empty_n_out));
endmodule // dffs_checker
bind dffs_top dffs_checker u_dffs_checker (.sys_clk_in, .sys_rst_in, .left_port_clock_in,
  .left_chip_select_n_in, .left_write_not_read_in, .left_mailbox_select_in,
  .left_transfer_enable_in, .left_data_out, .left_full_n_out, .left_almost_full_n_out,
  .left_empty_n_out, .left_almost_empty_n_out, .right_port_clock_in, .right_chip_select_n_in,
  .right_write_not_read_in, .right_mailbox_select_in, .right_transfer_enable_in,
  .right_size_sel_lo_in, .right_size_sel_hi_in, .right_full_n_out, .right_almost_full_n_out,
  .right_empty_n_out, .right_almost_empty_n_out);
`default_nettype wire

// ==== sim/dffs_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module dffs_top_tb_top;
  import dffs_pkg::*;
  logic sys_clk, sys_rst, l_cs_n, l_wnr, l_mb, l_en, r_cs_n, r_wnr, r_mb, r_en, r_lo, r_hi;
  logic [DFFS_WORD_W-1:0] l_d, r_d, l_q, r_q;
  wire logic l_clk, r_clk, l_full_n, l_af_n, l_empty_n, l_ae_n;
  wire logic r_full_n, r_af_n, r_empty_n, r_ae_n;
  int fails, tests_run;
  dffs_port_partner #(.HALF_NS(400), .PHASE_NS(30)) u_dffs_port_partner_left (.port_clk_out(l_clk));
  dffs_port_partner #(.HALF_NS(500), .PHASE_NS(70)) u_dffs_port_partner_right (.port_clk_out(r_clk));
  dffs_top u_dffs_top (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst),
    .left_port_clock_in(l_clk), .left_chip_select_n_in(l_cs_n), .left_write_not_read_in(l_wnr),
    .left_mailbox_select_in(l_mb), .left_transfer_enable_in(l_en), .left_data_in(l_d),
    .left_data_out(l_q), .left_full_n_out(l_full_n), .left_almost_full_n_out(l_af_n),
    .left_empty_n_out(l_empty_n), .left_almost_empty_n_out(l_ae_n),
    .right_port_clock_in(r_clk), .right_chip_select_n_in(r_cs_n), .right_write_not_read_in(r_wnr),
    .right_mailbox_select_in(r_mb), .right_transfer_enable_in(r_en), .right_size_sel_lo_in(r_lo),
    .right_size_sel_hi_in(r_hi), .right_data_in(r_d), .right_data_out(r_q),
    .right_full_n_out(r_full_n), .right_almost_full_n_out(r_af_n),
    .right_empty_n_out(r_empty_n), .right_almost_empty_n_out(r_ae_n));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Controls are held from before the port edge until after the pin falls again
  task automatic lacc(input logic w, input logic [35:0] d);
    @(negedge l_clk);
    @(negedge sys_clk);
    {l_cs_n, l_wnr, l_en, l_d} = {1'b0, w, 1'b1, d};
    @(posedge l_clk);
    @(negedge l_clk);
    @(negedge sys_clk);
    {l_cs_n, l_en} = 2'h2;
  endtask
  task automatic racc(input logic w, input logic [1:0] s, input logic [35:0] d);
    @(negedge r_clk);
    @(negedge sys_clk);
    {r_cs_n, r_wnr, r_en, r_hi, r_lo, r_d} = {1'b0, w, 1'b1, s, d};
    @(posedge r_clk);
    @(negedge r_clk);
    @(negedge sys_clk);
    {r_cs_n, r_en} = 2'h2;
  endtask
  // Three observer periods cover the slow release path
  task automatic settle;
    repeat (30) @(negedge sys_clk);
  endtask
  task automatic t_reset;
    `CHK({l_full_n, l_af_n, l_empty_n, l_ae_n, r_full_n, r_af_n, r_empty_n, r_ae_n}, 8'hcc)
  endtask
  task automatic t_fwd;
    int i;
    logic [35:0] w;
    for (i = 0; i < 9; i++) lacc(1'b1, 36'h100 + i);
    settle;
    `CHK(r_ae_n, 1'b1)
    for (i = 9; i < 23; i++) lacc(1'b1, 36'h100 + i);
    `CHK(l_af_n, 1'b1)
    lacc(1'b1, 36'h117);
    `CHK(l_af_n, 1'b0)
    for (i = 0; i < 4; i++) begin
      racc(1'b0, DFFS_SIZE_BYTE, 36'h0);
      w = 36'h100 >> (9 * i);
      `CHK(r_q, {27'h0, w[8:0]})
      if (i == 0) begin
        settle;
        `CHK(l_af_n, 1'b1)
      end
    end
    for (i = 24; i < 33; i++) lacc(1'b1, 36'h100 + i);
    `CHK(l_full_n, 1'b0)
    lacc(1'b1, 36'hfff);
    racc(1'b0, DFFS_SIZE_LONG, 36'h0);
    `CHK(r_q, 36'h101)
    settle;
    `CHK(l_full_n, 1'b1)
    lacc(1'b1, 36'h121);
    `CHK(l_full_n, 1'b0)
    racc(1'b0, DFFS_SIZE_WORD, 36'h0);
    `CHK(r_q, 36'h102)
    settle;
    `CHK(l_full_n, 1'b1)
    racc(1'b0, DFFS_SIZE_WORD, 36'h0);
    for (i = 3; i < 25; i++) begin
      racc(1'b0, DFFS_SIZE_LONG, 36'h0);
      `CHK(r_q, 36'h100 + i)
    end
    racc(1'b0, DFFS_SIZE_WORD, 36'h0);
    `CHK(r_ae_n, 1'b0)
    racc(1'b0, DFFS_SIZE_WORD, 36'h0);
    for (i = 26; i < 33; i++) racc(1'b0, DFFS_SIZE_LONG, 36'h0);
    racc(1'b0, DFFS_SIZE_WORD, 36'h0);
    `CHK(r_empty_n, 1'b1)
    racc(1'b0, DFFS_SIZE_WORD, 36'h0);
    `CHK(r_empty_n, 1'b0)
  endtask
  task automatic t_rev;
    int i;
    for (i = 0; i < 4; i++) begin
      racc(1'b1, DFFS_SIZE_BYTE, 36'h0a1 + i);
      if (i == 2) begin
        settle;
        `CHK(l_empty_n, 1'b0)
      end
    end
    settle;
    `CHK(l_empty_n, 1'b1)
    for (i = 0; i < 7; i++) racc(1'b1, DFFS_SIZE_LONG, 36'h200 + i);
    settle;
    `CHK(l_ae_n, 1'b0)
    racc(1'b1, DFFS_SIZE_LONG, 36'h207);
    settle;
    `CHK(l_ae_n, 1'b1)
    for (i = 8; i < 22; i++) racc(1'b1, DFFS_SIZE_LONG, 36'h200 + i);
    racc(1'b1, DFFS_SIZE_WORD, 36'h00abc);
    `CHK(r_af_n, 1'b1)
    racc(1'b1, DFFS_SIZE_WORD, 36'h00def);
    `CHK(r_af_n, 1'b0)
    for (i = 22; i < 29; i++) racc(1'b1, DFFS_SIZE_LONG, 36'h200 + i);
    racc(1'b1, DFFS_SIZE_WORD, 36'h00123);
    `CHK(r_full_n, 1'b1)
    racc(1'b1, DFFS_SIZE_WORD, 36'h00456);
    `CHK(r_full_n, 1'b0)
    lacc(1'b0, 36'h0);
    `CHK(l_q, {9'h0a4, 9'h0a3, 9'h0a2, 9'h0a1})
    settle;
    `CHK(r_full_n, 1'b1)
    for (i = 0; i < 8; i++) begin
      lacc(1'b0, 36'h0);
      `CHK(l_q, 36'h200 + i)
    end
    settle;
    `CHK(r_af_n, 1'b1)
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    fails = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    {l_cs_n, l_wnr, l_mb, l_en, r_cs_n, r_wnr, r_mb, r_en, r_lo, r_hi} = 10'h220;
    {l_d, r_d} = 72'h0;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset;
    t_fwd;
    t_rev;
    summarize;
  end
  // About 3000 cycles expected; allow ten thousand
  initial begin
    #1000000;
    fails++;
    summarize;
  end
endmodule // dffs_top_tb_top
`default_nettype wire
